// *** design/fieldbus_process_data_unit.sv ***
// process data unit: scaling, raw view, transfer error log, comms state, link config
// assumes APB master on clk_i, frame/parameter ports on clk_i, status pins asynchronous
//
// The APB register port and the register addresses were left to the implementer.
`include "fbpd_defines.svh"
`default_nettype none

// Function
// - internal full scale of 100.00 percent is 10000; selected references convert to it
// - full scale setting resets to 10000, giving unity scaling
// - only mask bits 5..0 matter; bit n-1 scales word n
// - mask resets to scale words two to five only
// - six raw received words readable, unscaled and unmodified
// - separate receive and transmit error flag words and totals
// - flag bits: 1 denied, 2/3 clamped, 4/5 bit range, 8 missing, 9 read denied
// - bit 7 flags stop-to-edit write while running, write dropped; others reserved
// - only the first error flagged per parameter write, every error per frame and read; totals count each erring transfer
// - totals wrap and clear on each link configuration
// - out-of-range numeric write is clamped to limit
// - out-of-range bit parameter write is not performed
// - zero pointer never flags or counts
// - comms state 0 online, 1 no valid address, 2 no traffic
// - comms state 3 when traffic seen but not polled or unsupported
// - writing 1 to configure starts configuration, control returns to 0
// - autoconfig 0 prevents and 1 allows configuration at power up
// - on link loss with fallback selected, holders give fallback values
module fieldbus_process_data_unit
  import fbpd_pkg::*;
#(
  parameter int NUM_WORDS = 6
) (
  input  wire logic         clk_i,          // 100 MHz clock
  input  wire logic         nrst_i,         // async reset, active low
  input  wire logic         psel_i,         // apb select
  input  wire logic         penable_i,      // apb enable
  input  wire logic         pwrite_i,       // apb direction
  input  wire logic [7:0]   paddr_i,        // apb byte address
  input  wire logic [31:0]  pwdata_i,       // apb write data
  output logic      [31:0]  prdata_o,       // apb read data
  output logic              pready_o,       // apb ready
  output logic              pslverr_o,      // apb error on unmapped address
  input  wire logic         rx_valid_i,     // one-cycle strobe of a received frame
  input  wire frame_words_t rx_words_i,     // six received words, word 1 at index 0
  input  wire logic         pw_valid_i,     // parameter write request strobe
  input  wire param_write_t pw_i,           // parameter write request
  input  wire logic         drive_running_i,// drive is running
  input  wire logic         pr_valid_i,     // parameter read report strobe
  input  wire param_read_t  pr_i,           // parameter read report
  input  wire logic         traffic_seen_i, // async: link rate deduced from traffic
  input  wire logic         polled_i,       // async: node polled with supported packet
  input  wire logic         link_lost_i,    // async: loss of link declared
  output logic              pw_write_o,     // parameter write performed, one cycle
  output logic      [15:0]  pw_value_o,     // value written to parameter
  output holders_t          holders_o,      // references and control words to drive
  output logic              configure_o,    // one-cycle link configuration attempt
  output logic              irq_o           // level interrupt
);

  // elaboration-time refusal of word counts the holder mapping cannot serve
  generate
    if (NUM_WORDS != 6) begin : g_bad_words
      $error("fieldbus_process_data_unit serves six words only");
    end
  endgenerate

  typedef struct packed {
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    word_t                       full_scale;
    word_t                       scale_mask;
    frame_words_t                raw;
    word_t                       rx_flags;
    word_t                       rx_total;
    word_t                       tx_flags;
    word_t                       tx_total;
    word_t                       station;
    logic                        autoconfig;
    logic                        configure_req;
    logic                        powerup_pend;
    logic                        configured;
    logic                        freeze_fb;
    word_t [6:0]                 fallback;
    holders_t                    held;
    holders_t                    out;
    logic [2:0][2:0]             sync;
    logic [2:0]                  pin;
    logic                        pw_write;
    word_t                       pw_value;
    logic                        configure;
    logic [`FBPD_IRQ_BITS-1:0]   irq_status;
    logic [`FBPD_IRQ_BITS-1:0]   irq_enable;
    logic                        irq;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // scaled and saturated value of each received word
  logic signed [31:0] scaled [NUM_WORDS];
  word_t              conv   [NUM_WORDS];
  logic [NUM_WORDS-1:0] clamp_lo;
  logic [NUM_WORDS-1:0] clamp_hi;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WORDS; gi++) begin : g_scale
      logic signed [31:0] prod;
      logic signed [31:0] div;
      logic               use_scale;
      assign use_scale = s_r.scale_mask[gi] && (s_r.full_scale != 16'h0000);
      assign prod = 32'(signed'(rx_words_i[gi])) * `FBPD_INTERNAL_FULL;
      assign div  = prod / 32'(signed'(s_r.full_scale));
      assign scaled[gi] = use_scale ? div : 32'(signed'(rx_words_i[gi]));
      // scaled words saturate to the holder range, unscaled words pass whole
      assign clamp_lo[gi] = use_scale && (scaled[gi] < `FBPD_REF_MIN);
      assign clamp_hi[gi] = use_scale && (scaled[gi] > `FBPD_REF_MAX);
      assign conv[gi] = clamp_lo[gi] ? 16'(`FBPD_REF_MIN) :
                        clamp_hi[gi] ? 16'(`FBPD_REF_MAX) : scaled[gi][15:0];
    end
  endgenerate

  logic        apb_wr;
  logic        apb_rd;
  logic [7:0]  a;
  logic        a_raw;
  logic        a_fb;
  logic [2:0]  raw_idx;
  logic [2:0]  fb_idx;
  logic        mapped;
  logic [31:0] rdata;
  logic        pw_err;
  logic        pr_err;
  logic        rx_err;
  word_t       pw_flags;
  word_t       pr_flags;
  word_t       frame_flags;
  logic        traffic;
  logic        polled;
  logic        lost;
  logic        lost_rise;
  logic        cfg_fire;
  logic [`FBPD_IRQ_BITS-1:0] irq_set;
  logic [`FBPD_IRQ_BITS-1:0] irq_clr;
  comms_state_t comms;

  always_comb begin
    s_nxt = s_r;
    a = paddr_i;
    apb_rd = psel_i && penable_i && !pwrite_i && !s_r.pready;
    apb_wr = psel_i && penable_i && pwrite_i && s_r.pready;
    a_raw = (a >= `FBPD_OFS_RAW_BASE) && (a < `FBPD_OFS_RAW_BASE + 8'h18);
    a_fb = (a >= `FBPD_OFS_FB_BASE) && (a < `FBPD_OFS_FB_BASE + 8'h1C);
    raw_idx = 3'((a - `FBPD_OFS_RAW_BASE) >> 2);
    fb_idx = 3'((a - `FBPD_OFS_FB_BASE) >> 2);
    traffic = s_r.pin[0];
    polled = s_r.pin[1];
    lost = s_r.pin[2];

    // comms state from the configured address and the filtered link pins
    if (!s_r.configured) begin
      comms = COMMS_NOT_CONFIGURED;
    end else if (!traffic) begin
      comms = COMMS_NO_NETWORK;
    end else if (!polled) begin
      comms = COMMS_NOT_COMMUNICATING;
    end else begin
      comms = COMMS_ONLINE;
    end

    // register read mux
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    if (a_raw && (a[1:0] == 2'b00)) begin
      rdata = {16'h0000, s_r.raw[raw_idx]};
    end else if (a_fb && (a[1:0] == 2'b00)) begin
      rdata = {16'h0000, s_r.fallback[fb_idx]};
    end else begin
      unique case (a)
        `FBPD_OFS_FULL_SCALE:  rdata = {16'h0000, s_r.full_scale};
        `FBPD_OFS_SCALE_MASK:  rdata = {16'h0000, s_r.scale_mask};
        `FBPD_OFS_RX_FLAGS:    rdata = {16'h0000, s_r.rx_flags};
        `FBPD_OFS_RX_TOTAL:    rdata = {16'h0000, s_r.rx_total};
        `FBPD_OFS_TX_FLAGS:    rdata = {16'h0000, s_r.tx_flags};
        `FBPD_OFS_TX_TOTAL:    rdata = {16'h0000, s_r.tx_total};
        `FBPD_OFS_COMMS_STATE: rdata = {30'h0, comms};
        `FBPD_OFS_STATION:     rdata = {16'h0000, s_r.station};
        `FBPD_OFS_AUTOCONFIG:  rdata = {31'h0, s_r.autoconfig};
        `FBPD_OFS_CONFIGURE:   rdata = {31'h0, s_r.configure_req};
        `FBPD_OFS_FREEZE_FB:   rdata = {31'h0, s_r.freeze_fb};
        `FBPD_OFS_IRQ_STATUS:  rdata = {28'h0000_000, s_r.irq_status};
        `FBPD_OFS_IRQ_ENABLE:  rdata = {28'h0000_000, s_r.irq_enable};
        `FBPD_OFS_IRQ_CLEAR:   rdata = 32'h0000_0000;
        default:               mapped = 1'b0;
      endcase
    end

    // apb: ready on the second access cycle, read data captured beside it
    s_nxt.pready = psel_i && penable_i && !s_r.pready;
    s_nxt.pslverr = psel_i && penable_i && !s_r.pready && !mapped;
    if (apb_rd) begin
      s_nxt.prdata = rdata;
    end

    irq_clr = '0;
    if (apb_wr) begin
      if (a_fb && (a[1:0] == 2'b00)) begin
        s_nxt.fallback[fb_idx] = pwdata_i[15:0];
      end
      unique case (a)
        `FBPD_OFS_FULL_SCALE: s_nxt.full_scale = pwdata_i[15:0];
        `FBPD_OFS_SCALE_MASK: s_nxt.scale_mask = pwdata_i[15:0];
        `FBPD_OFS_STATION:    s_nxt.station = pwdata_i[15:0];
        `FBPD_OFS_AUTOCONFIG: s_nxt.autoconfig = pwdata_i[0];
        `FBPD_OFS_CONFIGURE:  s_nxt.configure_req = pwdata_i[0];
        `FBPD_OFS_FREEZE_FB:  s_nxt.freeze_fb = pwdata_i[0];
        `FBPD_OFS_IRQ_ENABLE: s_nxt.irq_enable = pwdata_i[`FBPD_IRQ_BITS-1:0];
        `FBPD_OFS_IRQ_CLEAR:  irq_clr = pwdata_i[`FBPD_IRQ_BITS-1:0];
        default: ;
      endcase
    end

    // link configuration: explicit request, or once after power up if allowed
    cfg_fire = s_r.configure_req || (s_r.powerup_pend && s_r.autoconfig);
    s_nxt.configure = cfg_fire;
    if (cfg_fire) begin
      s_nxt.configure_req = 1'b0;
      s_nxt.powerup_pend = 1'b0;
      s_nxt.configured = (s_r.station <= `FBPD_MAX_STATION);
    end

    // asynchronous pins: three stages, accept once stages two and three agree
    for (int i = 0; i < 3; i++) begin
      s_nxt.sync[i] = {s_r.sync[i][1:0],
        (i == 0) ? traffic_seen_i : (i == 1) ? polled_i : link_lost_i};
      if (s_r.sync[i][1] == s_r.sync[i][2]) begin
        s_nxt.pin[i] = s_r.sync[i][2];
      end
    end
    lost_rise = s_nxt.pin[2] && !lost;

    // received frame: raw copy, scaled holders, clamp flags
    frame_flags = 16'h0000;
    rx_err = 1'b0;
    if (rx_valid_i) begin
      s_nxt.raw = rx_words_i;
      s_nxt.held.control_1 = conv[0];
      for (int i = 0; i < 5; i++) begin
        s_nxt.held.reference[i] = conv[i+1];
      end
      s_nxt.held.control_2 = conv[5];
      frame_flags[`FBPD_ERR_CLAMP_LOW] = |clamp_lo;
      frame_flags[`FBPD_ERR_CLAMP_HIGH] = |clamp_hi;
      rx_err = |clamp_lo || |clamp_hi;
    end

    // parameter write request from the receive side
    pw_flags = 16'h0000;
    s_nxt.pw_write = 1'b0;
    if (pw_valid_i && !pw_i.ptr_zero) begin
      s_nxt.pw_value = pw_i.value;
      if (pw_i.read_only) begin
        pw_flags[`FBPD_ERR_WR_DENIED] = 1'b1;
      end else if (pw_i.stop_to_edit && drive_running_i) begin
        pw_flags[`FBPD_ERR_STOP_EDIT] = 1'b1;
      end else if (pw_i.is_bit && (pw_i.value < pw_i.min)) begin
        pw_flags[`FBPD_ERR_BIT_LOW] = 1'b1;
      end else if (pw_i.is_bit && (pw_i.value > pw_i.max)) begin
        pw_flags[`FBPD_ERR_BIT_HIGH] = 1'b1;
      end else if (pw_i.value < pw_i.min) begin
        pw_flags[`FBPD_ERR_CLAMP_LOW] = 1'b1;
        s_nxt.pw_value = pw_i.min;
        s_nxt.pw_write = 1'b1;
      end else if (pw_i.value > pw_i.max) begin
        pw_flags[`FBPD_ERR_CLAMP_HIGH] = 1'b1;
        s_nxt.pw_value = pw_i.max;
        s_nxt.pw_write = 1'b1;
      end else begin
        s_nxt.pw_write = 1'b1;
      end
    end
    pw_err = |pw_flags;

    // parameter read report from the transmit side
    pr_flags = 16'h0000;
    if (pr_valid_i && !pr_i.ptr_zero) begin
      pr_flags[`FBPD_ERR_RD_MISSING] = pr_i.nonexistent;
      pr_flags[`FBPD_ERR_RD_DENIED] = pr_i.denied;
    end
    pr_err = |pr_flags;

    // error log: flags accumulate, totals wrap; configuration clears both
    if (cfg_fire) begin
      s_nxt.rx_flags = 16'h0000;
      s_nxt.rx_total = 16'h0000;
      s_nxt.tx_flags = 16'h0000;
      s_nxt.tx_total = 16'h0000;
    end else begin
      s_nxt.rx_flags = s_r.rx_flags | frame_flags | pw_flags;
      s_nxt.rx_total = s_r.rx_total + 16'(rx_err) + 16'(pw_err);
      s_nxt.tx_flags = s_r.tx_flags | pr_flags;
      s_nxt.tx_total = s_r.tx_total + 16'(pr_err);
    end

    // holders toward the drive: last value, or fallback while the link is lost
    s_nxt.out = s_nxt.held;
    if (s_nxt.pin[2] && s_r.freeze_fb) begin
      s_nxt.out.control_1 = s_r.fallback[0];
      s_nxt.out.control_2 = s_r.fallback[1];
      for (int i = 0; i < 5; i++) begin
        s_nxt.out.reference[i] = s_r.fallback[i+2];
      end
    end

    // interrupts: set wins over a clear in the same cycle
    irq_set = '0;
    irq_set[`FBPD_IRQ_RX_ERR] = rx_err || pw_err;
    irq_set[`FBPD_IRQ_TX_ERR] = pr_err;
    irq_set[`FBPD_IRQ_CONFIGURED] = cfg_fire;
    irq_set[`FBPD_IRQ_LINK_LOST] = lost_rise;
    s_nxt.irq_status = (s_r.irq_status & ~irq_clr) | irq_set;
    s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_enable);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '0;
      s_r.full_scale <= `FBPD_RST_FULL_SCALE;
      s_r.scale_mask <= `FBPD_RST_SCALE_MASK;
      s_r.station <= `FBPD_RST_STATION;
      s_r.freeze_fb <= `FBPD_RST_FREEZE_FB;
      s_r.powerup_pend <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o    = s_r.prdata;
  assign pready_o    = s_r.pready;
  assign pslverr_o   = s_r.pslverr;
  assign pw_write_o  = s_r.pw_write;
  assign pw_value_o  = s_r.pw_value;
  assign holders_o   = s_r.out;
  assign configure_o = s_r.configure;
  assign irq_o       = s_r.irq;

endmodule
`default_nettype wire

// *** pkg/fbpd_defines.svh ***
// register offsets, field positions, reset values and limits of the process data unit
// assumes a 32-bit APB register bus with byte addresses
`ifndef FBPD_DEFINES_SVH
`define FBPD_DEFINES_SVH

`define FBPD_OFS_FULL_SCALE   8'h00
`define FBPD_OFS_SCALE_MASK   8'h04
`define FBPD_OFS_RAW_BASE     8'h08
`define FBPD_OFS_RX_FLAGS     8'h20
`define FBPD_OFS_RX_TOTAL     8'h24
`define FBPD_OFS_TX_FLAGS     8'h28
`define FBPD_OFS_TX_TOTAL     8'h2C
`define FBPD_OFS_COMMS_STATE  8'h30
`define FBPD_OFS_STATION      8'h34
`define FBPD_OFS_AUTOCONFIG   8'h38
`define FBPD_OFS_CONFIGURE    8'h3C
`define FBPD_OFS_FREEZE_FB    8'h40
`define FBPD_OFS_FB_BASE      8'h44
`define FBPD_OFS_IRQ_STATUS   8'h60
`define FBPD_OFS_IRQ_ENABLE   8'h64
`define FBPD_OFS_IRQ_CLEAR    8'h68

`define FBPD_INTERNAL_FULL    32'sh0000_2710
`define FBPD_RST_FULL_SCALE   16'h2710
`define FBPD_RST_SCALE_MASK   16'h001E
`define FBPD_RST_STATION      16'h00FF
`define FBPD_MAX_STATION      16'h007F
`define FBPD_RST_FREEZE_FB    1'h1
`define FBPD_REF_MAX          32'sh0000_2710
`define FBPD_REF_MIN          -32'sh0000_2710

`define FBPD_ERR_WR_DENIED    1
`define FBPD_ERR_CLAMP_LOW    2
`define FBPD_ERR_CLAMP_HIGH   3
`define FBPD_ERR_BIT_LOW      4
`define FBPD_ERR_BIT_HIGH     5
`define FBPD_ERR_STOP_EDIT    7
`define FBPD_ERR_RD_MISSING   8
`define FBPD_ERR_RD_DENIED    9

`define FBPD_IRQ_RX_ERR       0
`define FBPD_IRQ_TX_ERR       1
`define FBPD_IRQ_CONFIGURED   2
`define FBPD_IRQ_LINK_LOST    3
`define FBPD_IRQ_BITS         4

`endif

// *** pkg/fbpd_pkg.sv ***
// types shared by the process data unit and its bench
// assumes fbpd_defines.svh is on the include path
`default_nettype none
package fbpd_pkg;
  typedef logic [15:0] word_t;
  typedef word_t [5:0] frame_words_t;

  typedef enum logic [1:0] {
    COMMS_ONLINE,
    COMMS_NOT_CONFIGURED,
    COMMS_NO_NETWORK,
    COMMS_NOT_COMMUNICATING
  } comms_state_t;

  // one write of a received value into a drive parameter
  typedef struct packed {
    logic signed [15:0] value;
    logic signed [15:0] min;
    logic signed [15:0] max;
    logic               is_bit;
    logic               read_only;
    logic               stop_to_edit;
    logic               ptr_zero;
  } param_write_t;

  // outcome of one read of a drive parameter for transmission
  typedef struct packed {
    logic nonexistent;
    logic denied;
    logic ptr_zero;
  } param_read_t;

  // references and control words handed to the drive
  typedef struct packed {
    word_t       control_1;
    word_t       control_2;
    word_t [4:0] reference;
  } holders_t;
endpackage
`default_nettype wire

// *** verif/fbpd_chk.sv ***
// port assertions of the process data unit
// assumes a bind from the bench top and one clock domain
`include "fbpd_defines.svh"
`default_nettype none
module fbpd_chk
  import fbpd_pkg::*;
(
  input wire logic         clk_i,           // clock
  input wire logic         nrst_i,          // reset, active low
  input wire logic         psel_i,          // apb select
  input wire logic         penable_i,       // apb enable
  input wire logic         pwrite_i,        // apb direction
  input wire logic [7:0]   paddr_i,         // apb address
  input wire logic [31:0]  pwdata_i,        // apb write data
  input wire logic [31:0]  prdata_o,        // apb read data
  input wire logic         pready_o,        // apb ready
  input wire logic         pslverr_o,       // apb error
  input wire logic         pw_valid_i,      // write request strobe
  input wire param_write_t pw_i,            // write request
  input wire logic         drive_running_i, // drive running
  input wire logic         pw_write_o,      // write performed
  input wire logic [15:0]  pw_value_o,      // value written
  input wire logic         configure_o      // configuration attempt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic cfg_wr;
  logic pw_ok;
  assign cfg_wr = psel_i && penable_i && pready_o && pwrite_i &&
                  paddr_i == `FBPD_OFS_CONFIGURE && pwdata_i[0];
  assign pw_ok = pw_valid_i && !pw_i.ptr_zero && !pw_i.read_only &&
                 !(pw_i.stop_to_edit && drive_running_i) && !pw_i.is_bit;
  chk_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready held two cycles");
  chk_ready_late: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready missing in second access cycle");
  chk_err_zero: assert property (pslverr_o && !pwrite_i |-> pready_o && prdata_o == 32'h0)
    else $error("refused read not zero");
  chk_upper_zero: assert property (pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0)
    else $error("upper read bits set");
  chk_cfg_start: assert property (cfg_wr |-> ##2 configure_o ##1 !configure_o)
    else $error("configure pulse wrong");
  chk_ptr_quiet: assert property (pw_valid_i && pw_i.ptr_zero |=> !pw_write_o)
    else $error("write from zero pointer");
  chk_bit_drop: assert property (pw_valid_i && pw_i.is_bit &&
    (pw_i.value > pw_i.max || pw_i.value < pw_i.min) |=> !pw_write_o)
    else $error("out of range bit write done");
  chk_stop_drop: assert property (pw_valid_i && pw_i.stop_to_edit && drive_running_i
    |=> !pw_write_o)
    else $error("stop to edit write done");
  chk_clamp_high: assert property (pw_ok && pw_i.value > pw_i.max
    |=> pw_write_o && pw_value_o == $past(pw_i.max))
    else $error("high clamp wrong");
  chk_clamp_low: assert property (pw_ok && pw_i.value < pw_i.min
    |=> pw_write_o && pw_value_o == $past(pw_i.min))
    else $error("low clamp wrong");
  cover property (configure_o);
  cover property (pw_write_o);
  cover property (pslverr_o);
endmodule
`default_nettype wire

// *** verif/fb_master_model.sv ***
// frame source standing in for the fieldbus master
// assumes the unit's clock; words are scrambled outside the strobe
`default_nettype none
module fb_master_model
  import fbpd_pkg::*;
(
  input  wire logic         clk_i,      // clock
  input  wire logic         nrst_i,     // reset, active low
  input  wire logic         send_i,     // request one frame
  input  wire frame_words_t words_i,    // words to send
  output logic              rx_valid_o, // frame strobe
  output frame_words_t      rx_words_o  // frame words
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_valid_o <= 1'b0;
      rx_words_o <= '0;
    end else begin
      rx_valid_o <= send_i;
      rx_words_o <= send_i ? words_i : ~rx_words_o;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench of the process data unit
// assumes design, package, frame model and checker compiled before
`include "fbpd_defines.svh"
`default_nettype none
module tb import fbpd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_i, nrst_i, psel, penable, pwrite, pw_valid, running, pr_valid;
  logic         traffic, polled, lost, f_go, rx_valid, pready, serr, pw_write, cfg, irq;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [15:0]  pw_value;
  param_write_t pw;
  param_read_t  pr;
  frame_words_t f_w, rx_words;
  holders_t     hold;
  int           n_fail = 0;
  int           checks = 0;
  int           n_cfg = 0;
  fb_master_model fm_u (.clk_i(clk_i), .nrst_i(nrst_i), .send_i(f_go), .words_i(f_w),
    .rx_valid_o(rx_valid), .rx_words_o(rx_words));
  fieldbus_process_data_unit dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(serr), .rx_valid_i(rx_valid),
    .rx_words_i(rx_words), .pw_valid_i(pw_valid), .pw_i(pw), .drive_running_i(running),
    .pr_valid_i(pr_valid), .pr_i(pr), .traffic_seen_i(traffic), .polled_i(polled),
    .link_lost_i(lost), .pw_write_o(pw_write), .pw_value_o(pw_value), .holders_o(hold),
    .configure_o(cfg), .irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (cfg === 1'b1) n_cfg++;
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
      n_fail++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    // only the watchdog ends a wait for ready
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask
  task automatic send(input frame_words_t w);
    @(posedge clk_i);
    {f_go, f_w} <= {1'b1, w};
    @(posedge clk_i);
    f_go <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pwr(input param_write_t p, input logic [16:0] ex);
    @(posedge clk_i);
    {pw_valid, pw} <= {1'b1, p};
    @(posedge clk_i);
    pw_valid <= 1'b0;
    @(posedge clk_i);
    chk("pw_out", {15'h0, ex}, {15'h0, pw_write, ex[16] ? pw_value : 16'h0});
  endtask
  task automatic prd(input param_read_t p);
    @(posedge clk_i);
    {pr_valid, pr} <= {1'b1, p};
    @(posedge clk_i);
    pr_valid <= 1'b0;
  endtask
  task automatic t_reset();
    rchk(`FBPD_OFS_FULL_SCALE, 32'h2710, "full_scale");
    rchk(`FBPD_OFS_SCALE_MASK, 32'h001E, "scale_mask");
    rchk(`FBPD_OFS_STATION, 32'h00FF, "station");
    rchk(`FBPD_OFS_FREEZE_FB, 32'h1, "freeze_fb");
    rchk(`FBPD_OFS_AUTOCONFIG, 32'h0, "autoconfig");
    apb(1'b1, `FBPD_OFS_RAW_BASE, 32'hFFFF);
    rchk(`FBPD_OFS_RAW_BASE, 32'h0, "raw_ro");
    apb(1'b0, 8'h70, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, serr});
  endtask
  task automatic t_scale();
    frame_words_t w = {16'h7FFF, 16'h0000, 16'h2710, 16'hE0C0, 16'h1388, 16'h8001};
    send(w);
    for (int i = 0; i < 6; i++) rchk(`FBPD_OFS_RAW_BASE + 8'(4 * i), {16'h0, w[i]}, "raw");
    for (int i = 0; i < 5; i++) chk("ref", {16'h0, w[i + 1]}, {16'h0, hold.reference[i]});
    chk("ctl", {w[0], w[5]}, {hold.control_1, hold.control_2});
    apb(1'b1, `FBPD_OFS_FULL_SCALE, 32'h4E20);
    apb(1'b1, `FBPD_OFS_SCALE_MASK, 32'hFFC3);
    send({16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'hF060, 16'h1000});
    chk("scaled_w1", 32'h0800, {16'h0, hold.control_1});
    chk("scaled_w2", 32'hF830, {16'h0, hold.reference[0]});
    chk("plain_w3", 32'h1000, {16'h0, hold.reference[1]});
    rchk(`FBPD_OFS_RAW_BASE + 8'h04, 32'hF060, "raw_w2");
    apb(1'b1, `FBPD_OFS_FULL_SCALE, 32'h2710);
  endtask
  task automatic t_errors();
    running <= 1'b1;
    pwr('{16'sd500, -16'sd100, 16'sd300, 0, 0, 0, 0}, 17'h1012C);
    pwr('{-16'sd200, -16'sd100, 16'sd300, 0, 0, 0, 0}, 17'h1FF9C);
    pwr('{16'sd2, 16'sd0, 16'sd1, 1, 0, 0, 0}, 17'h0);
    pwr('{-16'sd1, 16'sd0, 16'sd1, 1, 0, 0, 0}, 17'h0);
    pwr('{16'sd5, 16'sd0, 16'sd9, 0, 1, 0, 0}, 17'h0);
    pwr('{16'sd5, 16'sd0, 16'sd9, 0, 0, 1, 0}, 17'h0);
    pwr('{16'sd99, 16'sd0, 16'sd9, 0, 1, 0, 1}, 17'h0);
    rchk(`FBPD_OFS_RX_FLAGS, 32'h00BE, "rx_flags");
    rchk(`FBPD_OFS_RX_TOTAL, 32'h6, "rx_total");
    prd('{1, 0, 0});
    prd('{0, 1, 0});
    prd('{1, 1, 1});
    rchk(`FBPD_OFS_TX_FLAGS, 32'h0300, "tx_flags");
    rchk(`FBPD_OFS_TX_TOTAL, 32'h2, "tx_total");
  endtask
  task automatic t_irq();
    apb(1'b1, `FBPD_OFS_IRQ_ENABLE, 32'h3);
    rchk(`FBPD_OFS_IRQ_STATUS, 32'h3, "irq_status");
    chk("irq_set", 32'h1, {31'h0, irq});
    apb(1'b1, `FBPD_OFS_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, `FBPD_OFS_IRQ_CLEAR, 32'h3);
    apb(1'b1, `FBPD_OFS_IRQ_ENABLE, 32'h3);
    rchk(`FBPD_OFS_IRQ_STATUS, 32'h0, "irq_cleared");
    chk("irq_low", 32'h0, {31'h0, irq});
  endtask
  task automatic t_config();
    rchk(`FBPD_OFS_COMMS_STATE, 32'h1, "comms_unconf");
    chk("no_autocfg", 32'h0, n_cfg);
    apb(1'b1, `FBPD_OFS_STATION, 32'h0A);
    apb(1'b1, `FBPD_OFS_CONFIGURE, 32'h1);
    rchk(`FBPD_OFS_CONFIGURE, 32'h0, "cfg_clear");
    chk("cfg_pulses", 32'h1, n_cfg);
    rchk(`FBPD_OFS_RX_TOTAL, 32'h0, "rx_total_clr");
    rchk(`FBPD_OFS_TX_TOTAL, 32'h0, "tx_total_clr");
    rchk(`FBPD_OFS_COMMS_STATE, 32'h2, "comms_nonet");
    traffic <= 1'b1;
    repeat (8) @(posedge clk_i);
    rchk(`FBPD_OFS_COMMS_STATE, 32'h3, "comms_notpolled");
    polled <= 1'b1;
    repeat (8) @(posedge clk_i);
    rchk(`FBPD_OFS_COMMS_STATE, 32'h0, "comms_online");
  endtask
  task automatic t_fallback();
    apb(1'b1, `FBPD_OFS_FB_BASE + 8'h08, 32'h0123);
    send({6{16'h0555}});
    lost <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("fallback_ref1", 32'h0123, {16'h0, hold.reference[0]});
    apb(1'b1, `FBPD_OFS_FREEZE_FB, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("freeze_ref1", 32'h0555, {16'h0, hold.reference[0]});
  endtask
  task automatic t_autocfg();
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(1'b1, `FBPD_OFS_AUTOCONFIG, 32'h1);
    repeat (3) @(posedge clk_i);
    chk("autocfg_fire", 32'h2, n_cfg);
    rchk(`FBPD_OFS_COMMS_STATE, 32'h1, "comms_badaddr");
    rchk(`FBPD_OFS_IRQ_STATUS, 32'hC, "irq_cfg_lost");
  endtask
  task automatic close_out();
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {nrst_i, psel, penable, pwrite, pw_valid, running, pr_valid} = '0;
    {traffic, polled, lost, f_go, paddr, pwdata, pw, pr, f_w} = '0;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_scale();
    t_errors();
    t_irq();
    t_config();
    t_fallback();
    t_autocfg();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
endmodule
bind fieldbus_process_data_unit fbpd_chk chk_u (.clk_i, .nrst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pw_valid_i, .pw_i,
  .drive_running_i, .pw_write_o, .pw_value_o, .configure_o);
`default_nettype wire
